// ---- mbc_pkg.sv ----
/*
  Constants, field layouts, states and the check-code function shared by the
  multiport bank controller.
  Assumes a 10 MHz system clock; all times are converted to cycles here.
*/
package mbc_pkg;

  // ************************************************************
  // widths and sizes
  // ************************************************************
  localparam int CHAN_AW    = 21;      // channel address bits
  localparam int BANK_AW    = 18;      // internal bank address bits
  localparam int DW         = 16;      // data bits
  localparam int CW         = 5;       // check code bits
  localparam int SW         = 21;      // stored word bits
  localparam int LIM_W      = 6;       // limit switch value, 32K units
  localparam int BLK_SHIFT  = 15;      // log2 of 32K words
  localparam int MOD_WORDS  = 32768;   // words per storage module
  localparam int MOD_MAX    = 8;       // large bank
  localparam int MOD_MIN    = 4;       // small bank
  localparam int NPORT_MAX  = 4;
  localparam int CHAIN_MAX  = 10;      // ports on one daisy-chained channel
  localparam int LOG_AW     = 9;
  localparam int LOG_DEPTH  = 512;
  localparam int CRATE_W    = 3;
  localparam int ROW_W      = 7;       // refresh row counter width
  localparam int ECC_W      = 2;
  localparam int ECC_CHK_BIT = 0;      // check enable
  localparam int ECC_INV_BIT = 1;      // write inverted check code (test)
  localparam logic [ECC_W-1:0] ECC_RST = 2'h1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS      = 100;
  localparam int REFRESH_NS  = 15000;
  localparam int REFRESH_CYC = (REFRESH_NS / CLK_NS < 1) ? 1 : REFRESH_NS / CLK_NS;
  localparam int STORE_CYC   = 4;      // clocks per storage cycle

  // ************************************************************
  // grant sources: ports use their index 0..3
  // ************************************************************
  localparam logic [2:0] SRC_REF  = 3'h4;
  localparam logic [2:0] SRC_TEST = 3'h5;

  // ************************************************************
  // states and codes
  // ************************************************************
  typedef enum logic [1:0] {
    ACT_SCAN_LOG  = 2'h0,
    ACT_SCAN_PORT = 2'h1,
    ACT_LOAD_ECC  = 2'h2,
    ACT_TEST      = 2'h3
  } svc_act_t;

  typedef enum logic {
    ARB_IDLE  = 1'b0,
    ARB_CYCLE = 1'b1
  } arb_st_t;

  typedef enum logic [1:0] {
    SV_IDLE = 2'h0,
    SV_SCAN = 2'h1,
    SV_TEST = 2'h3,
    SV_DONE = 2'h2
  } svc_st_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic               req;
    logic               we;
    logic [CHAN_AW-1:0] addr;
  } chan_addr_t;

  typedef struct packed {
    logic [DW-1:0] wdata;
  } chan_data_t;

  typedef struct packed {
    logic [LIM_W-1:0] lower_limit;
    logic [LIM_W-1:0] upper_limit;
  } port_lim_t;

  typedef struct packed {
    logic               strobe;
    logic               we;
    logic               refresh;
    logic [BANK_AW-1:0] addr;
    logic [SW-1:0]      wdata;
  } stor_req_t;

  typedef struct packed {
    logic               strobe;
    logic [1:0]         act;
    logic [1:0]         port;
    logic               we;
    logic [BANK_AW-1:0] addr;
    logic [DW-1:0]      data;
  } svc_cmd_t;

  // ************************************************************
  // check code over 16 data bits
  // ************************************************************
  function automatic logic [CW-1:0] ecc_gen(input logic [DW-1:0] d);
    logic [CW-1:0] c;
    c[0] = d[0] ^ d[1] ^ d[2] ^ d[3] ^ d[4] ^ d[6] ^ d[8] ^ d[10];
    c[1] = d[0] ^ d[2] ^ d[4] ^ d[7] ^ d[9] ^ d[10] ^ d[12] ^ d[14];
    c[2] = d[1] ^ d[2] ^ d[5] ^ d[7] ^ d[11] ^ d[12] ^ d[15];
    c[3] = d[3] ^ d[4] ^ d[5] ^ d[6] ^ d[7] ^ d[13] ^ d[14] ^ d[15];
    c[4] = d[8] ^ d[9] ^ d[10] ^ d[11] ^ d[12] ^ d[13] ^ d[14] ^ d[15];
    return c;
  endfunction

endpackage

// ---- multiport_bank_controller.sv ----
/*
  One memory bank: channel ports with limit decode and check code, a
  last-port-first arbiter with periodic refresh, an error log and the
  service channel actions.
  Assumes channel, limit, switch and service inputs are asynchronous pins;
  the storage array runs on sys_clk and returns read data by the last
  clock of a storage cycle.
*/
`timescale 1ns/100ps

module multiport_bank_controller
  import mbc_pkg::*;
#(
  parameter int NPORT   = NPORT_MAX,
  parameter int MODULES = MOD_MAX
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire chan_addr_t             chan_a   [NPORT],
  input  wire chan_data_t             chan_d   [NPORT],
  input  wire port_lim_t              port_lim [NPORT],
  output logic       [NPORT-1:0]      chan_ready,
  output logic       [DW-1:0]         chan_rdata [NPORT],
  output logic       [NPORT-1:0]      chan_err,
  output stor_req_t                   stor_req,
  input  wire logic  [SW-1:0]         stor_rdata,
  input  wire svc_cmd_t               svc_cmd,
  input  wire logic  [CRATE_W-1:0]    crate_sw,
  output logic       [DW-1:0]         scan_word,
  output logic                        svc_done
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  initial begin
    if (NPORT < 1 || NPORT > NPORT_MAX || NPORT > CHAIN_MAX) begin
      $error("port count out of range");
    end
    if (MODULES != MOD_MAX && MODULES != MOD_MIN) begin
      $error("module count must be 4 or 8");
    end
  end

  localparam logic [CHAN_AW-1:0] BANK_WORDS = CHAN_AW'(MODULES * MOD_WORDS);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  chan_addr_t               ca_s1_r   [NPORT];
  chan_addr_t               ca_s2_r   [NPORT];
  chan_data_t               cd_s1_r   [NPORT];
  chan_data_t               cd_s2_r   [NPORT];
  port_lim_t                lim_s1_r  [NPORT];
  port_lim_t                lim_s2_r  [NPORT];
  svc_cmd_t                 svc_s1_r;
  svc_cmd_t                 svc_s2_r;
  logic                     svc_stb_d_r;
  logic [CRATE_W-1:0]       crate_s1_r;
  logic [CRATE_W-1:0]       crate_r;

  // address and data bundles are captured separately
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NPORT; i++) begin
        ca_s1_r[i]  <= '0;
        ca_s2_r[i]  <= '0;
        cd_s1_r[i]  <= '0;
        cd_s2_r[i]  <= '0;
        lim_s1_r[i] <= '0;
        lim_s2_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        ca_s1_r[i]  <= chan_a[i];
        ca_s2_r[i]  <= ca_s1_r[i];
        cd_s1_r[i]  <= chan_d[i];
        cd_s2_r[i]  <= cd_s1_r[i];
        lim_s1_r[i] <= port_lim[i];
        lim_s2_r[i] <= lim_s1_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      svc_s1_r    <= '0;
      svc_s2_r    <= '0;
      svc_stb_d_r <= 1'b0;
      crate_s1_r  <= '0;
      crate_r     <= '0;
    end else begin
      svc_s1_r    <= svc_cmd;
      svc_s2_r    <= svc_s1_r;
      svc_stb_d_r <= svc_s2_r.strobe;
      crate_s1_r  <= crate_sw;
      crate_r     <= crate_s1_r;
    end
  end

  wire svc_go = svc_s2_r.strobe && !svc_stb_d_r;

  // ************************************************************
  // port address decode
  // ************************************************************
  logic [NPORT-1:0]         hit;
  logic [BANK_AW-1:0]       baddr [NPORT];

  always_comb begin
    logic [CHAN_AW-1:0] lo;
    logic [CHAN_AW-1:0] hi;
    logic [CHAN_AW-1:0] diff;
    lo   = '0;
    hi   = '0;
    diff = '0;
    for (int i = 0; i < NPORT; i++) begin
      lo       = {lim_s2_r[i].lower_limit, BLK_SHIFT'(0)};
      hi       = {lim_s2_r[i].upper_limit, BLK_SHIFT'(0)};
      diff     = ca_s2_r[i].addr - lo;
      baddr[i] = diff[BANK_AW-1:0];
      hit[i]   = ca_s2_r[i].req && (ca_s2_r[i].addr >= lo)
                 && (ca_s2_r[i].addr < hi) && (diff < BANK_WORDS);
    end
  end

  // ************************************************************
  // served-request flags: a port must drop its request to rearm
  // ************************************************************
  logic [NPORT-1:0]         done_r;
  logic [NPORT-1:0]         pend;
  logic [NPORT-1:0]         fin_port;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      done_r <= '0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (fin_port[i]) begin
          done_r[i] <= 1'b1;
        end else if (!ca_s2_r[i].req) begin
          done_r[i] <= 1'b0;
        end
      end
    end
  end

  assign pend = hit & ~done_r;

  // ************************************************************
  // refresh request and row counter
  // ************************************************************
  logic [$clog2(REFRESH_CYC+1)-1:0] ref_cnt_r;
  logic                     ref_pend_r;
  logic [ROW_W-1:0]         ref_row_r;
  logic                     grant_ref;
  logic                     grant_test;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt_r  <= '0;
      ref_pend_r <= 1'b0;
    end else begin
      if (grant_ref) begin
        ref_pend_r <= 1'b0;
      end
      if (ref_cnt_r == $bits(ref_cnt_r)'(REFRESH_CYC - 1)) begin
        ref_cnt_r  <= '0;
        ref_pend_r <= 1'b1;
      end else begin
        ref_cnt_r  <= ref_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_row_r <= '0;
    end else if (grant_ref) begin
      ref_row_r <= ref_row_r + 1'b1;
    end
  end

  // ************************************************************
  // priority pick
  // ************************************************************
  arb_st_t                  arb_st_r;
  logic [2:0]               last_r;
  logic                     last_v_r;
  logic                     test_pend_r;
  logic                     pick_v;
  logic [2:0]               pick;

  always_comb begin
    pick_v = 1'b0;
    pick   = '0;
    if (last_v_r && pend[last_r[1:0]]) begin
      pick_v = 1'b1;
      pick   = last_r;
    end else if (ref_pend_r) begin
      pick_v = 1'b1;
      pick   = SRC_REF;
    end else begin
      for (int i = NPORT - 1; i >= 0; i--) begin
        if (pend[i]) begin
          pick_v = 1'b1;
          pick   = 3'(i);
        end
      end
      if (!pick_v && test_pend_r) begin
        pick_v = 1'b1;
        pick   = SRC_TEST;
      end
    end
  end

  wire grant = (arb_st_r == ARB_IDLE) && pick_v;
  assign grant_ref  = grant && (pick == SRC_REF);
  assign grant_test = grant && (pick == SRC_TEST);

  // ************************************************************
  // storage cycle
  // ************************************************************
  logic [ECC_W-1:0]         ecc_ctl_r [NPORT];
  logic [2:0]               src_r;
  logic [$clog2(STORE_CYC+1)-1:0] cyc_r;
  logic                     test_fin_r;
  logic [DW-1:0]            test_rd_r;
  logic                     log_set;
  logic [LOG_AW-1:0]        log_set_a;
  logic [ECC_W-1:0]         g_ctl;
  logic [ECC_W-1:0]         c_ctl;
  logic [CW-1:0]            synd;
  logic                     cyc_end;

  always_comb begin
    g_ctl = (pick == SRC_TEST) ? ecc_ctl_r[svc_s2_r.port] : ecc_ctl_r[pick[1:0]];
    c_ctl = (src_r == SRC_TEST) ? ecc_ctl_r[svc_s2_r.port] : ecc_ctl_r[src_r[1:0]];
  end

  assign cyc_end  = (arb_st_r == ARB_CYCLE) && (cyc_r == $bits(cyc_r)'(STORE_CYC - 1));
  assign synd     = ecc_gen(stor_rdata[DW-1:0]) ^ stor_rdata[SW-1:DW];
  assign log_set  = cyc_end && !stor_req.we && !stor_req.refresh
                    && c_ctl[ECC_CHK_BIT] && (synd != '0);
  assign log_set_a = {stor_req.addr[BANK_AW-1:BLK_SHIFT-1], synd};

  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      fin_port[i] = cyc_end && (src_r == 3'(i));
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arb_st_r <= ARB_IDLE;
      stor_req <= '0;
      src_r    <= '0;
      cyc_r    <= '0;
      last_r   <= '0;
      last_v_r <= 1'b0;
    end else begin
      case (arb_st_r)
        ARB_IDLE: begin
          if (grant) begin
            arb_st_r       <= ARB_CYCLE;
            src_r          <= pick;
            cyc_r          <= '0;
            stor_req.strobe  <= 1'b1;
            stor_req.refresh <= (pick == SRC_REF);
            if (pick == SRC_REF) begin
              stor_req.we    <= 1'b0;
              stor_req.addr  <= BANK_AW'(ref_row_r);
              stor_req.wdata <= '0;
            end else if (pick == SRC_TEST) begin
              stor_req.we    <= svc_s2_r.we;
              stor_req.addr  <= svc_s2_r.addr;
              stor_req.wdata <= {ecc_gen(svc_s2_r.data) ^ {CW{g_ctl[ECC_INV_BIT]}}, svc_s2_r.data};
            end else begin
              stor_req.we    <= ca_s2_r[pick[1:0]].we;
              stor_req.addr  <= baddr[pick[1:0]];
              stor_req.wdata <= {ecc_gen(cd_s2_r[pick[1:0]].wdata) ^ {CW{g_ctl[ECC_INV_BIT]}},
                                 cd_s2_r[pick[1:0]].wdata};
              last_r         <= pick;
              last_v_r       <= 1'b1;
            end
          end
        end
        ARB_CYCLE: begin
          cyc_r <= cyc_r + 1'b1;
          if (cyc_end) begin
            arb_st_r        <= ARB_IDLE;
            stor_req.strobe <= 1'b0;
          end
        end
        default: begin
          arb_st_r <= ARB_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // channel answers
  // ************************************************************
  logic [NPORT-1:0]         port_err_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chan_ready <= '0;
      chan_err   <= '0;
      port_err_r <= '0;
      test_fin_r <= 1'b0;
      test_rd_r  <= '0;
      for (int i = 0; i < NPORT; i++) begin
        chan_rdata[i] <= '0;
      end
    end else begin
      test_fin_r <= cyc_end && (src_r == SRC_TEST);
      if (cyc_end && (src_r == SRC_TEST)) begin
        test_rd_r <= stor_rdata[DW-1:0];
      end
      for (int i = 0; i < NPORT; i++) begin
        chan_ready[i] <= fin_port[i];
        chan_err[i]   <= fin_port[i] && log_set;
        if (fin_port[i] && !stor_req.we) begin
          chan_rdata[i] <= stor_rdata[DW-1:0];
        end
        if (fin_port[i] && log_set) begin
          port_err_r[i] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // error log
  // ************************************************************
  logic [LOG_DEPTH-1:0]     log_r;
  logic                     log_clr;
  logic [LOG_AW-1:0]        scan_ptr_r;

  // clear first so a simultaneous new error stays recorded
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      log_r <= '0;
    end else begin
      if (log_clr) begin
        log_r[scan_ptr_r] <= 1'b0;
      end
      if (log_set) begin
        log_r[log_set_a] <= 1'b1;
      end
    end
  end

  // ************************************************************
  // service channel actions
  // ************************************************************
  svc_st_t                  svc_st_r;

  assign log_clr = (svc_st_r == SV_SCAN) && log_r[scan_ptr_r];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      svc_st_r    <= SV_IDLE;
      scan_ptr_r  <= '0;
      scan_word   <= '0;
      svc_done    <= 1'b0;
      test_pend_r <= 1'b0;
      for (int i = 0; i < NPORT; i++) begin
        ecc_ctl_r[i] <= ECC_RST;
      end
    end else begin
      svc_done <= 1'b0;
      if (grant_test) begin
        test_pend_r <= 1'b0;
      end
      case (svc_st_r)
        SV_IDLE: begin
          if (svc_go) begin
            case (svc_act_t'(svc_s2_r.act))
              ACT_SCAN_LOG: begin
                scan_ptr_r <= '0;
                svc_st_r   <= SV_SCAN;
              end
              ACT_SCAN_PORT: begin
                scan_word <= '0;
                if (32'(svc_s2_r.port) < NPORT) begin
                  scan_word <= {2'h0, 1'b1, port_err_r[svc_s2_r.port],
                                lim_s2_r[svc_s2_r.port]};
                end
                svc_st_r <= SV_DONE;
              end
              ACT_LOAD_ECC: begin
                if (32'(svc_s2_r.port) < NPORT) begin
                  ecc_ctl_r[svc_s2_r.port] <= svc_s2_r.data[ECC_W-1:0];
                end
                svc_st_r <= SV_DONE;
              end
              ACT_TEST: begin
                test_pend_r <= 1'b1;
                svc_st_r    <= SV_TEST;
              end
              default: begin
                svc_st_r <= SV_DONE;
              end
            endcase
          end
        end
        SV_SCAN: begin
          if (log_r[scan_ptr_r]) begin
            scan_word <= {3'h0, 1'b1, crate_r, scan_ptr_r};
            svc_st_r  <= SV_DONE;
          end else if (scan_ptr_r == LOG_AW'(LOG_DEPTH - 1)) begin
            scan_word <= {3'h0, 1'b0, crate_r, LOG_AW'(0)};
            svc_st_r  <= SV_DONE;
          end else begin
            scan_ptr_r <= scan_ptr_r + 1'b1;
          end
        end
        SV_TEST: begin
          if (test_fin_r) begin
            scan_word <= test_rd_r;
            svc_st_r  <= SV_DONE;
          end
        end
        SV_DONE: begin
          svc_done <= 1'b1;
          svc_st_r <= SV_IDLE;
        end
        default: begin
          svc_st_r <= SV_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- mbc_properties.sv ----
/* port checker for multiport_bank_controller
   bound onto every instance of the controller, sees its ports only */
`timescale 1ns/100ps
module mbc_properties
  import mbc_pkg::*;
#(parameter int NPORT = 4) (
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire chan_addr_t       chan_a [NPORT],
  input wire logic [NPORT-1:0] chan_ready,
  input wire logic [NPORT-1:0] chan_err,
  input wire stor_req_t        stor_req,
  input wire svc_cmd_t         svc_cmd,
  input wire logic             svc_done
);
  // ******
  // helpers
  // ******
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [NPORT-1:0] reqv;
  logic [7:0]       ref_cnt_r;
  always_comb begin
    for (int i = 0; i < NPORT; i++) reqv[i] = chan_a[i].req;
  end
  // cycles since the last refresh cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) ref_cnt_r <= 8'h0;
    else if (stor_req.refresh) ref_cnt_r <= 8'h0;
    else if (ref_cnt_r != 8'hff) ref_cnt_r <= ref_cnt_r + 8'h1;
  end
  // ******
  // properties
  // ******
  AST_ONE_READY: assert property ($onehot0(chan_ready))
    else $error("two ports answered at once");
  AST_CYCLE_LEN: assert property ($rose(stor_req.strobe) |-> stor_req.strobe[*4] ##1 !stor_req.strobe)
    else $error("storage cycle length wrong");
  AST_ADDR_HOLD: assert property (stor_req.strobe && $past(stor_req.strobe) |-> $stable(stor_req.addr))
    else $error("address moved within a cycle");
  AST_READY_END: assert property (|chan_ready |-> !stor_req.strobe && $past(stor_req.strobe))
    else $error("ready outside cycle end");
  AST_READY_REQ: assert property (|chan_ready |-> (chan_ready & ~$past(reqv, 4)) == '0)
    else $error("ready without request");
  AST_ERR_READY: assert property (|chan_err |-> (chan_err & ~chan_ready) == '0)
    else $error("error flag without ready");
  AST_REF_PERIOD: assert property (ref_cnt_r < 8'hc8)
    else $error("refresh overdue");
  AST_REF_READ: assert property (stor_req.strobe && stor_req.refresh |-> !stor_req.we)
    else $error("refresh cycle writes");
  AST_SVC_QUICK: assert property ($rose(svc_cmd.strobe) && ^svc_cmd.act |-> ##[2:5] svc_done)
    else $error("port action late");
  AST_SVC_BOUND: assert property ($rose(svc_cmd.strobe) |-> ##[1:600] svc_done)
    else $error("service action hung");
  cover property (stor_req.strobe && stor_req.refresh);
  cover property (|chan_err);
  cover property (svc_done && svc_cmd.act == 2'h0);
endmodule
bind multiport_bank_controller mbc_properties #(.NPORT(NPORT)) u_mbc_properties (.sys_clk(sys_clk), .nrst(nrst),
  .chan_a(chan_a), .chan_ready(chan_ready), .chan_err(chan_err), .stor_req(stor_req), .svc_cmd(svc_cmd),
  .svc_done(svc_done));

// ---- mbc_storage_model.sv ----
/* storage array model behind the bank controller
   256 words; flip corrupts read words on purpose */
`timescale 1ns/100ps
module mbc_storage_model
  import mbc_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire stor_req_t     stor_req,
  input  wire logic [SW-1:0] flip,
  output logic      [SW-1:0] stor_rdata
);
  // ******
  // array
  // ******
  logic [SW-1:0] mem [256];
  logic [SW-1:0] last_r = '0;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = '0;
  end
  always @(posedge sys_clk) begin
    if (stor_req.strobe && stor_req.we) mem[stor_req.addr[7:0]] <= stor_req.wdata;
    if (stor_req.strobe) last_r <= stor_rdata;
  end
  // outside a read the bus shows the inverse of the last word
  assign stor_rdata = (stor_req.strobe && !stor_req.we) ? mem[stor_req.addr[7:0]] ^ flip : ~last_r;
endmodule

// ---- multiport_bank_controller_bench.sv ----
/* self-checking bench for multiport_bank_controller
   drives four channels and the service pins; storage model behind */
`timescale 1ns/100ps
module multiport_bank_controller_bench;
  import mbc_pkg::*;
  // ******
  // stimulus signals
  // ******
  logic          sys_clk = 1'b0;
  logic          nrst = 1'b0;
  chan_addr_t    chan_a [4];
  chan_data_t    chan_d [4];
  port_lim_t     port_lim [4];
  logic [3:0]    chan_ready, chan_err;
  logic [DW-1:0] chan_rdata [4];
  stor_req_t     stor_req;
  logic [SW-1:0] stor_rdata, flip = '0;
  svc_cmd_t      svc_cmd = '0;
  logic [2:0]    crate_sw = 3'h5;
  logic [DW-1:0] scan_word, rd;
  logic          svc_done, er, strobe_q = 1'b0;
  logic [6:0]    ref_row;
  int            failures = 0, checks = 0, ref_n = 0;
  integer        seed = 32'h9022;
  logic [17:0]   order [$];
  multiport_bank_controller #(.NPORT(4), .MODULES(8)) u_multiport_bank_controller (.sys_clk(sys_clk), .nrst(nrst),
    .chan_a(chan_a), .chan_d(chan_d), .port_lim(port_lim), .chan_ready(chan_ready), .chan_rdata(chan_rdata),
    .chan_err(chan_err), .stor_req(stor_req), .stor_rdata(stor_rdata), .svc_cmd(svc_cmd), .crate_sw(crate_sw),
    .scan_word(scan_word), .svc_done(svc_done));
  mbc_storage_model u_mbc_storage_model (.sys_clk(sys_clk), .stor_req(stor_req), .flip(flip), .stor_rdata(stor_rdata));
  always #50 sys_clk = ~sys_clk;
  // ******
  // helpers
  // ******
  function automatic logic [4:0] code(input logic [15:0] d);
    return {^(d & 16'hff00), ^(d & 16'he0f8), ^(d & 16'h98a6), ^(d & 16'h5695), ^(d & 16'h055f)};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // grant order and refresh rows seen on the storage side
  always @(posedge sys_clk) begin
    strobe_q <= stor_req.strobe;
    if (stor_req.strobe && !strobe_q && !stor_req.refresh) order.push_back(stor_req.addr);
    if (stor_req.strobe && !strobe_q && stor_req.refresh) begin
      if (ref_n > 0) check(stor_req.addr[6:0], 7'(ref_row + 7'h1));
      ref_row = stor_req.addr[6:0];
      ref_n++;
    end
  end
  task automatic access(input int p, input logic we, input logic [20:0] a, input logic [15:0] d, input logic hit);
    int n;
    n = 0;
    @(posedge sys_clk);
    chan_a[p] <= {1'b1, we, a};
    chan_d[p] <= d;
    while (chan_ready[p] !== 1'b1 && n < 80) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    rd = chan_rdata[p];
    er = chan_err[p];
    check(n < 80, hit);
    @(posedge sys_clk);
    chan_a[p].req <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic svc(input logic [1:0] act, input logic [1:0] p, input logic we, input logic [17:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    svc_cmd <= {1'b1, act, p, we, a, d};
    while (svc_done !== 1'b1 && n < 700) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(n < 700, 1'b1);
    @(posedge sys_clk);
    svc_cmd.strobe <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // ******
  // sequence
  // ******
  initial begin
    logic [15:0] d [8];
    logic [20:0] a [8];
    for (int i = 0; i < 4; i++) begin
      chan_a[i] = '0;
      chan_d[i] = '0;
      port_lim[i] = (i == 3) ? {6'h2, 6'h4} : {6'h0, 6'h8};
    end
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      d[i] = 16'($random(seed));
      a[i] = 21'(i * 32) | 21'($random(seed) & 31);
      access(i % 3, 1'b1, a[i], d[i], 1'b1);
      check(u_mbc_storage_model.mem[a[i][7:0]], {code(d[i]), d[i]});
    end
    for (int i = 0; i < 8; i++) begin
      order.delete();
      access(3, 1'b0, a[i] + 21'h10000, 16'h0, 1'b1);
      check(order[0], a[i][17:0]);
      check({rd, er}, {d[i], 1'b0});
    end
    access(3, 1'b0, 21'h20000, 16'h0, 1'b0);
    access(3, 1'b0, 21'h0ffff, 16'h0, 1'b0);
    access(2, 1'b0, 21'h0, 16'h0, 1'b1);
    order.delete();
    fork
      access(0, 1'b0, 21'h10, 16'h0, 1'b1);
      access(1, 1'b0, 21'h11, 16'h0, 1'b1);
      access(2, 1'b0, 21'h12, 16'h0, 1'b1);
      access(3, 1'b0, 21'h10013, 16'h0, 1'b1);
    join
    check({order[0][7:0], order[1][7:0], order[2][7:0], order[3][7:0]}, 32'h12101113);
    order.delete();
    fork
      begin
        access(0, 1'b0, 21'h20, 16'h0, 1'b1);
        access(0, 1'b0, 21'h22, 16'h0, 1'b1);
      end
      access(1, 1'b0, 21'h21, 16'h0, 1'b1);
    join
    check({order[0][7:0], order[1][7:0], order[2][7:0]}, 24'h202122);
    flip <= 21'h1;
    access(0, 1'b0, a[0], 16'h0, 1'b1);
    check({rd, er}, {d[0] ^ 16'h1, 1'b1});
    flip <= '0;
    svc(2'h0, 2'h0, 1'b0, 18'h0, 16'h0);
    check(scan_word, {3'h0, 1'b1, 3'h5, 4'h0, 5'h03});
    svc(2'h0, 2'h0, 1'b0, 18'h0, 16'h0);
    check(scan_word, {3'h0, 1'b0, 3'h5, 9'h0});
    svc(2'h1, 2'h0, 1'b0, 18'h0, 16'h0);
    check(scan_word, {2'h0, 1'b1, 1'b1, 6'h0, 6'h8});
    svc(2'h1, 2'h3, 1'b0, 18'h0, 16'h0);
    check(scan_word, {2'h0, 1'b1, 1'b0, 6'h2, 6'h4});
    svc(2'h2, 2'h0, 1'b0, 18'h0, 16'h0);
    flip <= 21'h1;
    access(0, 1'b0, a[0], 16'h0, 1'b1);
    check(er, 1'b0);
    flip <= '0;
    svc(2'h2, 2'h0, 1'b0, 18'h0, 16'h3);
    access(0, 1'b1, a[1], d[1], 1'b1);
    check(u_mbc_storage_model.mem[a[1][7:0]], {~code(d[1]), d[1]});
    svc(2'h2, 2'h0, 1'b0, 18'h0, 16'h1);
    svc(2'h3, 2'h0, 1'b1, 18'h40, 16'hbeef);
    check(u_mbc_storage_model.mem[8'h40], {code(16'hbeef), 16'hbeef});
    svc(2'h3, 2'h0, 1'b0, 18'h40, 16'h0);
    check(scan_word, 16'hbeef);
    check(ref_n > 2, 1'b1);
    summarize();
  end
  // whole sequence takes some 1200 cycles; allow 25 times that
  initial begin
    #(100 * 30000);
    failures++;
    summarize();
  end
endmodule
